// *** design/cfg_pkg.sv ***
// Overview of operation
// [RULE_01] All configuration registers keep their contents through sleep; host writes are ignored while asleep.
// [RULE_02] Bit 6 of each pin configuration register inverts that pin's selected signal; it resets to 0.
// [RULE_03] Pin two's select field, bits 5:0, resets to 0x29, the active-low device ready indication.
// [RULE_04] Pin one's select field resets to 0x2E, which leaves that pin undriven.
// [RULE_05] Pin zero's select field resets to 0x3F, the crystal oscillator clock divided by 192.
// [RULE_06] Bit 7 of pin one's register sets high or low drive strength for all three pins; it resets to 0.
// [RULE_07] Bit 7 of pin zero's register enables the temperature sensor, and the host then writes zero to the others.
// [RULE_08] A queue threshold counts as reached when its byte count is equal to or above the threshold.
// [RULE_09] Setting n gives 61 minus 4n bytes for transmit and 4(n+1) bytes for receive, with reset setting 7.
// [RULE_10] Bits 7:4 of the threshold register read as zero and the host writes zeros there.
// [RULE_11] The sync word's upper byte has its own register, resetting to 0xD3.
// [RULE_12] The sync word's lower byte has its own register, resetting to 0x91.
// [RULE_13] With fixed length enabled, the length register gives the exact packet length; it resets to 0xFF.
// [RULE_14] With variable length, the same register gives the largest accepted packet length.
// [RULE_15] The host reads and writes the registers over the serial interface, with bursts over consecutive addresses.
// [RULE_16] Each pin drives the signal picked by its select field, exclusive-ORed with its polarity bit.
// [RULE_17] Bit 7 of pin two's register ignores writes and reads as zero.
package cfg_pkg;
    localparam int ADDR_W = 6;
    localparam logic [5:0] ADDR_PIN_TWO = 6'h00;
    localparam logic [5:0] ADDR_PIN_ONE = 6'h01;
    localparam logic [5:0] ADDR_PIN_ZERO = 6'h02;
    localparam logic [5:0] ADDR_QUEUE_THRESHOLD_SELECT = 6'h03;
    localparam logic [5:0] ADDR_MARK_HIGH = 6'h04;
    localparam logic [5:0] ADDR_MARK_LOW = 6'h05;
    localparam logic [5:0] ADDR_SIZE_LIMIT = 6'h06;

    localparam int POLARITY_BIT = 6;
    localparam int DRIVE_BIT = 7;
    localparam int TEMP_BIT = 7;
    localparam int SELECT_MSB = 5;
    localparam int THR_MSB = 3;
    localparam int HDR_READ_BIT = 7;
    localparam int HDR_BURST_BIT = 6;

    localparam logic [5:0] PIN_TWO_SELECT_RESET = 6'h29;
    localparam logic [5:0] PIN_ONE_SELECT_RESET = 6'h2E;
    localparam logic [5:0] PIN_ZERO_SELECT_RESET = 6'h3F;
    localparam logic [5:0] SELECT_UNDRIVEN = 6'h2E;
    localparam logic [3:0] THR_RESET = 4'h7;
    localparam logic [7:0] MARK_HIGH_RESET = 8'hD3;
    localparam logic [7:0] MARK_LOW_RESET = 8'h91;
    localparam logic [7:0] SIZE_LIMIT_RESET = 8'hFF;

    localparam logic [6:0] TX_THR_BASE = 7'h3D;
    localparam logic [6:0] THR_STEP = 7'h04;
    localparam int COUNT_W = 7;
    localparam int SOURCE_COUNT = 64;
endpackage

// *** design/spi_byte_if.sv ***
`timescale 1ns/10ps
interface spi_byte_if;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_first;
    logic [7:0] tx_data;

    modport link (output rx_data, output rx_valid, output rx_first, input tx_data);
    modport regs (input rx_data, input rx_valid, input rx_first, output tx_data);
endinterface

// *** design/spi_frame.sv ***
`timescale 1ns/10ps
// serial clock is sampled by the system clock; it must stay at least two system clocks in each phase
module spi_frame (
    input wire logic clock,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_low,
    input wire logic mosi,
    output logic miso_r,
    output logic miso_oe_r,
    spi_byte_if.link bytes
);
    logic sclk_d_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_in_r;
    logic [7:0] shift_out_r;
    logic first_r;
    logic rx_valid_r;
    logic [7:0] rx_data_r;
    logic rx_first_r;

    wire selected = !cs_low;
    wire rise = selected && sclk && !sclk_d_r;
    wire fall = selected && !sclk && sclk_d_r;
    wire byte_done = rise && (bit_cnt_r == 3'h7);
    wire byte_start = fall && (bit_cnt_r == 3'h0);

    assign bytes.rx_data = rx_data_r;
    assign bytes.rx_valid = rx_valid_r;
    assign bytes.rx_first = rx_first_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sclk_d_r <= 1'b0;
            bit_cnt_r <= 3'h0;
            shift_in_r <= 8'h00;
            shift_out_r <= 8'h00;
            first_r <= 1'b1;
            rx_valid_r <= 1'b0;
            rx_data_r <= 8'h00;
            rx_first_r <= 1'b0;
            miso_r <= 1'b0;
            miso_oe_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk;
            miso_oe_r <= selected;
            rx_valid_r <= byte_done;
            if (!selected) begin
                bit_cnt_r <= 3'h0;
                first_r <= 1'b1;
                shift_out_r <= bytes.tx_data;
                miso_r <= bytes.tx_data[7];
            end else begin
                if (rise) begin
                    shift_in_r <= {shift_in_r[6:0], mosi};
                    bit_cnt_r <= bit_cnt_r + 3'h1;
                end
                if (byte_done) begin
                    rx_data_r <= {shift_in_r[6:0], mosi};
                    rx_first_r <= first_r;
                    first_r <= 1'b0;
                end
                // next byte is fetched at its first falling edge so burst reads see the advanced address
                if (byte_start) begin
                    shift_out_r <= {bytes.tx_data[6:0], 1'b0};
                    miso_r <= bytes.tx_data[7];
                end else if (fall) begin
                    shift_out_r <= {shift_out_r[6:0], 1'b0};
                    miso_r <= shift_out_r[7];
                end
            end
        end
    end
endmodule

// *** design/pin_driver.sv ***
`timescale 1ns/10ps
module pin_driver #(
    parameter int SOURCES = 64
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [SOURCES-1:0] sources,
    input wire logic [5:0] select,
    input wire logic polarity,
    output logic pin_r,
    output logic pin_oe_r
);
    import cfg_pkg::*;

    initial begin
        if (SOURCES != 64) $error("pin_driver needs one source per select code");
    end

    wire picked = sources[select];
    wire driven = (select != SELECT_UNDRIVEN);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_r <= 1'b0;
            pin_oe_r <= 1'b0;
        end else begin
            pin_r <= picked ^ polarity; // [RULE_16] [RULE_02]
            pin_oe_r <= driven; // [RULE_04]
        end
    end
endmodule

// *** design/radio_pin_fifo_packet_config.sv ***
`timescale 1ns/10ps
module radio_pin_fifo_packet_config #(
    parameter int FIFO_DEPTH = 64
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_low,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic sleep_state,
    input wire logic [cfg_pkg::SOURCE_COUNT-1:0] pin_sources,
    input wire logic [cfg_pkg::COUNT_W-1:0] tx_fifo_count,
    input wire logic [cfg_pkg::COUNT_W-1:0] rx_fifo_count,
    input wire logic fixed_length_mode,
    input wire logic [7:0] rx_packet_length,
    output logic general_output_pin_zero,
    output logic general_output_pin_zero_oe,
    output logic general_output_pin_one,
    output logic general_output_pin_one_oe,
    output logic general_output_pin_two,
    output logic general_output_pin_two_oe,
    output logic pin_drive_strength,
    output logic temp_sensor_enable,
    output logic tx_threshold_reached,
    output logic rx_threshold_reached,
    output logic [15:0] frame_mark,
    output logic [7:0] frame_size_limit,
    output logic length_accepted
);
    import cfg_pkg::*;

    initial begin
        if (FIFO_DEPTH != 64) $error("threshold table assumes a 64 byte queue");
    end

    function automatic logic [COUNT_W-1:0] tx_limit(input logic [3:0] n);
        tx_limit = TX_THR_BASE - THR_STEP * {3'h0, n};
    endfunction

    function automatic logic [COUNT_W-1:0] rx_limit(input logic [3:0] n);
        rx_limit = THR_STEP * ({3'h0, n} + 7'h01);
    endfunction

    // register state; nothing here is cleared by sleep, only by rst
    logic pin_two_polarity_r;
    logic [5:0] pin_two_select_r;
    logic pin_drive_strength_r;
    logic pin_one_polarity_r;
    logic [5:0] pin_one_select_r;
    logic temp_enable_r;
    logic pin_zero_polarity_r;
    logic [5:0] pin_zero_select_r;
    logic [3:0] queue_threshold_select_r;
    logic [7:0] frame_mark_high_r;
    logic [7:0] frame_mark_low_r;
    logic [7:0] frame_size_limit_r;

    // serial transaction state
    logic active_r;
    logic read_r;
    logic burst_r;
    logic [ADDR_W-1:0] addr_r;

    logic tx_reached_r;
    logic rx_reached_r;
    logic length_ok_r;

    spi_byte_if bytes ();

    spi_frame u_frame (
        .clock(clock),
        .rst(rst),
        .sclk(spi_sclk),
        .cs_low(spi_cs_low),
        .mosi(spi_mosi),
        .miso_r(spi_miso),
        .miso_oe_r(spi_miso_oe),
        .bytes(bytes.link)
    );

    // header byte: read flag, burst flag, 6-bit address
    wire header_seen = bytes.rx_valid && bytes.rx_first;
    wire data_seen = bytes.rx_valid && !bytes.rx_first && active_r;
    wire write_strobe = data_seen && !read_r && !sleep_state; // [RULE_15] [RULE_01]

    wire wr_pin_two = write_strobe && (addr_r == ADDR_PIN_TWO);
    wire wr_pin_one = write_strobe && (addr_r == ADDR_PIN_ONE);
    wire wr_pin_zero = write_strobe && (addr_r == ADDR_PIN_ZERO);
    wire wr_queue_threshold_select = write_strobe && (addr_r == ADDR_QUEUE_THRESHOLD_SELECT);
    wire wr_mark_high = write_strobe && (addr_r == ADDR_MARK_HIGH);
    wire wr_mark_low = write_strobe && (addr_r == ADDR_MARK_LOW);
    wire wr_size_limit = write_strobe && (addr_r == ADDR_SIZE_LIMIT);

    wire [7:0] wdata = bytes.rx_data;

    wire [7:0] rd_pin_two = {1'b0, pin_two_polarity_r, pin_two_select_r}; // [RULE_17]
    wire [7:0] rd_pin_one = {pin_drive_strength_r, pin_one_polarity_r, pin_one_select_r};
    wire [7:0] rd_pin_zero = {temp_enable_r, pin_zero_polarity_r, pin_zero_select_r};
    wire [7:0] rd_queue_threshold_select = {4'h0, queue_threshold_select_r}; // [RULE_10]

    // unmapped addresses read as zero
    wire [7:0] read_value =
        (addr_r == ADDR_PIN_TWO) ? rd_pin_two :
        (addr_r == ADDR_PIN_ONE) ? rd_pin_one :
        (addr_r == ADDR_PIN_ZERO) ? rd_pin_zero :
        (addr_r == ADDR_QUEUE_THRESHOLD_SELECT) ? rd_queue_threshold_select :
        (addr_r == ADDR_MARK_HIGH) ? frame_mark_high_r :
        (addr_r == ADDR_MARK_LOW) ? frame_mark_low_r :
        (addr_r == ADDR_SIZE_LIMIT) ? frame_size_limit_r : 8'h00;

    // status byte during the header is left at zero
    assign bytes.tx_data = (active_r && read_r) ? read_value : 8'h00; // [RULE_15]

    wire [COUNT_W-1:0] tx_thr = tx_limit(queue_threshold_select_r); // [RULE_09]
    wire [COUNT_W-1:0] rx_thr = rx_limit(queue_threshold_select_r); // [RULE_09]

    wire length_fits = fixed_length_mode ? (rx_packet_length == frame_size_limit_r) // [RULE_13]
                                         : (rx_packet_length <= frame_size_limit_r); // [RULE_14]

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            active_r <= 1'b0;
            read_r <= 1'b0;
            burst_r <= 1'b0;
            addr_r <= '0;
        end else if (header_seen) begin
            active_r <= 1'b1;
            read_r <= bytes.rx_data[HDR_READ_BIT];
            burst_r <= bytes.rx_data[HDR_BURST_BIT];
            addr_r <= bytes.rx_data[SELECT_MSB:0];
        end else if (data_seen) begin
            // single access ends after one byte; a burst walks on to the next address
            active_r <= burst_r;
            addr_r <= addr_r + 6'h01; // [RULE_15]
        end else if (spi_cs_low) begin
            // a burst left open must not leak read data into the next header byte
            active_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_two_polarity_r <= 1'b0; // [RULE_02]
            pin_two_select_r <= PIN_TWO_SELECT_RESET; // [RULE_03]
        end else if (wr_pin_two) begin
            pin_two_polarity_r <= wdata[POLARITY_BIT];
            pin_two_select_r <= wdata[SELECT_MSB:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_drive_strength_r <= 1'b0; // [RULE_06]
            pin_one_polarity_r <= 1'b0;
            pin_one_select_r <= PIN_ONE_SELECT_RESET; // [RULE_04]
        end else if (wr_pin_one) begin
            pin_drive_strength_r <= wdata[DRIVE_BIT]; // [RULE_06]
            pin_one_polarity_r <= wdata[POLARITY_BIT];
            pin_one_select_r <= wdata[SELECT_MSB:0];
        end
    end

    // the host clears the other fields when it sets the sensor bit; stored as written
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            temp_enable_r <= 1'b0;
            pin_zero_polarity_r <= 1'b0;
            pin_zero_select_r <= PIN_ZERO_SELECT_RESET; // [RULE_05]
        end else if (wr_pin_zero) begin
            temp_enable_r <= wdata[TEMP_BIT]; // [RULE_07]
            pin_zero_polarity_r <= wdata[POLARITY_BIT];
            pin_zero_select_r <= wdata[SELECT_MSB:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            queue_threshold_select_r <= THR_RESET; // [RULE_09]
        end else if (wr_queue_threshold_select) begin
            queue_threshold_select_r <= wdata[THR_MSB:0]; // [RULE_10]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            frame_mark_high_r <= MARK_HIGH_RESET; // [RULE_11]
            frame_mark_low_r <= MARK_LOW_RESET; // [RULE_12]
            frame_size_limit_r <= SIZE_LIMIT_RESET; // [RULE_13]
        end else begin
            if (wr_mark_high) begin
                frame_mark_high_r <= wdata; // [RULE_11]
            end
            if (wr_mark_low) begin
                frame_mark_low_r <= wdata; // [RULE_12]
            end
            if (wr_size_limit) begin
                frame_size_limit_r <= wdata;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_reached_r <= 1'b0;
            rx_reached_r <= 1'b0;
            length_ok_r <= 1'b0;
        end else begin
            tx_reached_r <= (tx_fifo_count >= tx_thr); // [RULE_08]
            rx_reached_r <= (rx_fifo_count >= rx_thr); // [RULE_08]
            length_ok_r <= length_fits;
        end
    end

    pin_driver #(.SOURCES(SOURCE_COUNT)) u_pin_zero (
        .clock(clock),
        .rst(rst),
        .sources(pin_sources),
        .select(pin_zero_select_r),
        .polarity(pin_zero_polarity_r),
        .pin_r(general_output_pin_zero),
        .pin_oe_r(general_output_pin_zero_oe)
    );

    pin_driver #(.SOURCES(SOURCE_COUNT)) u_pin_one (
        .clock(clock),
        .rst(rst),
        .sources(pin_sources),
        .select(pin_one_select_r),
        .polarity(pin_one_polarity_r),
        .pin_r(general_output_pin_one),
        .pin_oe_r(general_output_pin_one_oe)
    );

    pin_driver #(.SOURCES(SOURCE_COUNT)) u_pin_two (
        .clock(clock),
        .rst(rst),
        .sources(pin_sources),
        .select(pin_two_select_r),
        .polarity(pin_two_polarity_r),
        .pin_r(general_output_pin_two),
        .pin_oe_r(general_output_pin_two_oe)
    );

    assign pin_drive_strength = pin_drive_strength_r;
    assign temp_sensor_enable = temp_enable_r;
    assign tx_threshold_reached = tx_reached_r;
    assign rx_threshold_reached = rx_reached_r;
    assign frame_mark = {frame_mark_high_r, frame_mark_low_r};
    assign frame_size_limit = frame_size_limit_r;
    assign length_accepted = length_ok_r;
endmodule

// *** sim/spi_host.sv ***
`timescale 1ns/10ps
module spi_host (
    input wire logic clock,
    output logic sclk,
    output logic cs_low,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_low = 1'b1;
        mosi = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // mode 0, msb first; three clocks per phase leaves margin over the two-clock sampling limit
    task automatic frame(input logic [7:0] hdr, ref logic [7:0] buf_q[$]);
        logic [7:0] sh;
        cs_low = 1'b0;
        tick(3);
        for (int i = 0; i <= buf_q.size(); i++) begin
            sh = (i == 0) ? hdr : buf_q[i-1];
            for (int b = 7; b >= 0; b--) begin
                mosi = sh[b];
                tick(3);
                sclk = 1'b1;
                if (i > 0) buf_q[i-1][b] = miso;
                tick(3);
                sclk = 1'b0;
            end
        end
        tick(3);
        cs_low = 1'b1;
        // line not selected: show no stale bit
        mosi = ~mosi;
        tick(3);
    endtask
endmodule

// *** sim/radio_cfg_sva.sv ***
`timescale 1ns/10ps
module radio_cfg_sva #(
    parameter int FIFO_DEPTH = 64
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic spi_cs_low,
    input wire logic spi_miso_oe,
    input wire logic sleep_state,
    input wire logic [6:0] tx_fifo_count,
    input wire logic [6:0] rx_fifo_count,
    input wire logic fixed_length_mode,
    input wire logic [7:0] rx_packet_length,
    input wire logic pin_drive_strength,
    input wire logic tx_threshold_reached,
    input wire logic rx_threshold_reached,
    input wire logic [15:0] frame_mark,
    input wire logic [7:0] frame_size_limit,
    input wire logic length_accepted
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // four samples cover the strobe of any write that could land
    sequence asleep_s;
        sleep_state [*4];
    endsequence
    sequence idle_s;
        spi_cs_low [*2];
    endsequence
    sequence busy_s;
        !spi_cs_low ##1 !spi_cs_low;
    endsequence
    a_tx_full_hit: assert property (tx_fifo_count >= 7'h3D |=> tx_threshold_reached)
        else $error("tx flag low at full count");
    a_tx_empty_clear: assert property (tx_fifo_count == 7'h00 |=> !tx_threshold_reached)
        else $error("tx flag high at empty");
    a_rx_full_hit: assert property (rx_fifo_count >= 7'h40 |=> rx_threshold_reached)
        else $error("rx flag low at full count");
    a_rx_low_clear: assert property (rx_fifo_count < 7'h04 |=> !rx_threshold_reached)
        else $error("rx flag high below minimum");
    a_sleep_keeps_values: assert property (asleep_s |-> $stable(frame_mark) && $stable(frame_size_limit)
        && $stable(pin_drive_strength)) else $error("value changed during sleep");
    a_miso_idle_off: assert property (idle_s |-> !spi_miso_oe)
        else $error("miso driven while deselected");
    a_miso_frame_on: assert property (busy_s |-> spi_miso_oe)
        else $error("miso not driven while selected");
    a_len_fixed_eq: assert property (fixed_length_mode && $stable(frame_size_limit) |=>
        length_accepted == ($past(rx_packet_length) == $past(frame_size_limit))) else $error("fixed length verdict");
    a_len_var_max: assert property (!fixed_length_mode && $stable(frame_size_limit) |=>
        length_accepted == ($past(rx_packet_length) <= $past(frame_size_limit))) else $error("variable length verdict");
    a_write_in_frame: assert property ($changed(frame_mark) || $changed(frame_size_limit) |->
        !$past(spi_cs_low)) else $error("register changed outside a frame");
endmodule
bind radio_pin_fifo_packet_config radio_cfg_sva #(.FIFO_DEPTH(FIFO_DEPTH)) sva_u (.clock(clock), .rst(rst),
    .spi_cs_low(spi_cs_low), .spi_miso_oe(spi_miso_oe), .sleep_state(sleep_state), .tx_fifo_count(tx_fifo_count),
    .rx_fifo_count(rx_fifo_count), .fixed_length_mode(fixed_length_mode), .rx_packet_length(rx_packet_length),
    .pin_drive_strength(pin_drive_strength), .tx_threshold_reached(tx_threshold_reached),
    .rx_threshold_reached(rx_threshold_reached), .frame_mark(frame_mark), .frame_size_limit(frame_size_limit),
    .length_accepted(length_accepted));

// *** sim/radio_pin_fifo_packet_config_bench.sv ***
`timescale 1ns/10ps
module radio_pin_fifo_packet_config_bench;
    import cfg_pkg::*;
    `define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic sclk, cs_low, mosi, miso, miso_oe, drive, temp, tx_hit, rx_hit, len_ok;
    logic sleep_state = 1'b0;
    logic fixed_length_mode = 1'b0;
    logic [63:0] pin_sources = 64'h0;
    logic [6:0] tx_fifo_count = 7'h00;
    logic [6:0] rx_fifo_count = 7'h00;
    logic [7:0] rx_packet_length = 8'h00;
    logic [2:0] pins, pins_oe;
    logic [15:0] frame_mark;
    logic [7:0] size_lim;
    logic [7:0] regs_exp[7];
    logic [7:0] q[$];
    logic [31:0] seed = 32'h00015D22;
    int mismatches = 0;
    int checks_done = 0;
    always #4 clock = ~clock;
    spi_host host_u (.clock(clock), .sclk(sclk), .cs_low(cs_low), .mosi(mosi), .miso(miso));
    radio_pin_fifo_packet_config #(.FIFO_DEPTH(64)) dut_u (.clock(clock), .rst(rst), .spi_sclk(sclk),
        .spi_cs_low(cs_low), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe), .sleep_state(sleep_state),
        .pin_sources(pin_sources), .tx_fifo_count(tx_fifo_count), .rx_fifo_count(rx_fifo_count),
        .fixed_length_mode(fixed_length_mode), .rx_packet_length(rx_packet_length),
        .general_output_pin_zero(pins[0]), .general_output_pin_zero_oe(pins_oe[0]),
        .general_output_pin_one(pins[1]), .general_output_pin_one_oe(pins_oe[1]),
        .general_output_pin_two(pins[2]), .general_output_pin_two_oe(pins_oe[2]), .pin_drive_strength(drive),
        .temp_sensor_enable(temp), .tx_threshold_reached(tx_hit), .rx_threshold_reached(rx_hit),
        .frame_mark(frame_mark), .frame_size_limit(size_lim), .length_accepted(len_ok));
    function automatic logic [7:0] rnd();
        repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    task automatic close_out();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check_outputs();
        logic [5:0] s;
        repeat (2) @(posedge clock);
        #1;
        for (int k = 0; k < 3; k++) begin
            s = regs_exp[2-k][5:0];
            `CHK(pins[k], pin_sources[s] ^ regs_exp[2-k][6])
            `CHK(pins_oe[k], s != SELECT_UNDRIVEN)
        end
        `CHK(drive, regs_exp[1][7])
        `CHK(temp, regs_exp[2][7])
        `CHK(frame_mark, {regs_exp[4], regs_exp[5]})
        `CHK(size_lim, regs_exp[6])
    endtask
    task automatic read_all();
        q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        host_u.frame(8'hC0, q);
        for (int k = 0; k < 7; k++) `CHK(q[k], regs_exp[k])
        `CHK(miso_oe, 1'b0)
    endtask
    initial begin
        for (int c = 0; c < 60000; c++) @(posedge clock);
        mismatches++;
        close_out();
    end
    initial begin
        regs_exp = '{8'h29, 8'h2E, 8'h3F, 8'h07, 8'hD3, 8'h91, 8'hFF};
        for (int b = 0; b < 8; b++) pin_sources[8*b +: 8] = rnd();
        repeat (10) @(posedge clock);
        #1;
        rst = 1'b0;
        check_outputs();
        read_all();
        for (int it = 0; it < 4; it++) begin
            for (int b = 0; b < 8; b++) pin_sources[8*b +: 8] = rnd();
            for (int k = 0; k < 7; k++) regs_exp[k] = rnd();
            if (it == 0) regs_exp[1][5:0] = SELECT_UNDRIVEN;
            if (it == 1) regs_exp[0][7] = 1'b1;
            if (it == 2) regs_exp[2] = 8'h80;
            if (regs_exp[2][7]) regs_exp[2] = 8'h80;
            regs_exp[3][7:4] = 4'h0;
            q = {};
            for (int k = 0; k < 7; k++) q.push_back(regs_exp[k]);
            host_u.frame(8'h40, q);
            // reserved bit must not stick
            regs_exp[0][7] = 1'b0;
            read_all();
            check_outputs();
        end
        for (int n = 0; n < 16; n++) begin
            q = '{8'(n)};
            host_u.frame(8'h03, q);
            for (int d = 0; d < 2; d++) begin
                tx_fifo_count = 7'(60 - 4 * n + d);
                rx_fifo_count = 7'(4 * n + 3 + d);
                repeat (2) @(posedge clock);
                #1;
                `CHK(tx_hit, d[0])
                `CHK(rx_hit, d[0])
            end
        end
        regs_exp[3] = 8'h0F;
        sleep_state = 1'b1;
        q = '{~regs_exp[4]};
        host_u.frame(8'h04, q);
        sleep_state = 1'b0;
        // single access: the second byte must not reach the next address
        q = '{8'h5A, 8'h34};
        host_u.frame(8'h06, q);
        regs_exp[6] = 8'h5A;
        read_all();
        q = '{8'h55};
        host_u.frame(8'h3A, q);
        q = '{8'hFF, 8'hFF};
        host_u.frame(8'hBA, q);
        `CHK(q[0], 8'h00)
        `CHK(q[1], 8'h00)
        for (int m = 0; m < 6; m++) begin
            fixed_length_mode = m[0];
            rx_packet_length = 8'h59 + 8'(m / 2);
            repeat (2) @(posedge clock);
            #1;
            `CHK(len_ok, m[0] ? (m / 2 == 1) : (m / 2 < 2))
        end
        close_out();
    end
endmodule
